// File: logic/telegram_defines.svh
// Constants of the telegram field formatter and status block.
// Assumes a 50 MHz clock; included by the formatter module telegram_field_format_status.
`ifndef TELEGRAM_DEFINES_SVH
`define TELEGRAM_DEFINES_SVH

// ****************************************
// Field descriptors
// ****************************************
`define TFS_CHECK_ID      5'd24
`define TFS_DEF_WIDTH     5'd3
`define TFS_DEF_DEC       2'd0
`define TFS_DEF_FMT       2'd0
`define TFS_NP_WIDTH      3'd1
`define TFS_NP_DEC        3'd2
`define TFS_NP_FMT_NUM    3'd3
`define TFS_NP_FMT_INT    3'd2

// ****************************************
// Characters
// ****************************************
`define TFS_CH_ZERO       8'h30
`define TFS_CH_HEXOFS     8'h37
`define TFS_CH_DOT        8'h2e
`define TFS_CH_PLUS       8'h2b
`define TFS_CH_MINUS      8'h2d

// ****************************************
// Timing
// ****************************************
`define TFS_CLK_PERIOD_NS 20
`define TFS_TICK_MS       1000
`define TFS_TICK_CYCLES   (`TFS_TICK_MS * 1000000 / `TFS_CLK_PERIOD_NS)
`define TFS_NOVAL_S       10
`define TFS_FAULT_S       60
`define TFS_AVG_LONG_S    10

// ****************************************
// Extended and short status layout
// ****************************************
`define TFS_ST_MALF       0
`define TFS_ST_CRIT       1
`define TFS_ST_HEAT       2
`define TFS_ST_STATIC     4
`define TFS_ST_FILL       8
`define TFS_SH_FILL       1
`define TFS_SH_STATIC     5
`define TFS_SH_CRIT       6
`define TFS_SH_HEAT       7
`define TFS_FILL_STEPS    16

// ****************************************
// Sizes
// ****************************************
`define TFS_FIFO_DEPTH    16
`define TFS_HIST_DEPTH    64
`define TFS_WMAX          16

`endif

// File: logic/telegram_pkg.sv
// Types shared by the telegram field formatter modules.
// Assumes telegram_defines.svh is on the include path.
package telegram_pkg;

  typedef enum logic [1:0] {
    FMT_UDEC,
    FMT_SDEC,
    FMT_UHEX,
    FMT_SHEX
  } num_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_BUILD,
    ST_EMIT
  } fmt_state_t;

endpackage

// File: logic/char_stream_if.sv
// Character stream with valid and ready between design modules.
// Assumes source and sink share mclk_i.
`timescale 1ns/1ps
interface char_stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// File: logic/char_fifo.sv
// Synchronous FIFO for the outgoing telegram characters.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic    mclk_i,
  input  wire logic    rst_b_i,
  // Streams
  char_stream_if.snk   in_s,
  char_stream_if.src   out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data  = mem_reg[rd_reg];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: logic/telegram_field_format_status.sv
// Telegram field formatter, check total and extended status word.
// Assumes all inputs come from logic on mclk_i; the host drains out_*.
`timescale 1ns/1ps
`include "telegram_defines.svh"

module telegram_field_format_status
  import telegram_pkg::*;
#(
  parameter int TICK_CYCLES = `TFS_TICK_CYCLES,
  parameter int IDXW        = 8,
  parameter int HIST_DEPTH  = `TFS_HIST_DEPTH,
  parameter int FIFO_DEPTH  = `TFS_FIFO_DEPTH,
  parameter int WMAX        = `TFS_WMAX,
  parameter int FILLW       = 16
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // Field request
  input  wire logic              fld_valid_i,
  output logic                   fld_ready_o,
  input  wire logic [4:0]        fld_id_i,
  input  wire logic              fld_is_number_i,
  input  wire logic [2:0]        fld_nparams_i,
  input  wire logic [31:0]       fld_value_i,
  input  wire logic [4:0]        fld_width_i,
  input  wire logic [1:0]        fld_dec_i,
  input  wire logic [1:0]        fld_fmt_i,
  input  wire logic [IDXW-1:0]   fld_first_i,
  input  wire logic [IDXW-1:0]   fld_last_i,
  // Fixed text characters
  input  wire logic              tel_start_i,
  input  wire logic              text_valid_i,
  output logic                   text_ready_o,
  input  wire logic [7:0]        text_data_i,
  // Telegram character output
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [7:0]             out_data_o,
  output logic [IDXW-1:0]        char_count_o,
  // Status sources
  input  wire logic              new_value_i,
  input  wire logic [FILLW-1:0]  avg_time_s_i,
  input  wire logic [FILLW-1:0]  fill_count_i,
  input  wire logic [FILLW-1:0]  fill_cap_i,
  input  wire logic              heat_crit_i,
  input  wire logic              heater_on_i,
  input  wire logic              fault_i,
  // Status words
  output logic [15:0]            ext_status_o,
  output logic [7:0]             short_status_o
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int WW  = $clog2(WMAX) + 1;
  localparam int BW  = $clog2(WMAX);
  localparam int HAW = $clog2(HIST_DEPTH);
  localparam int FW4 = FILLW + 4;
  localparam int TW  = $clog2(TICK_CYCLES + 1);

  fmt_state_t       st_reg;
  logic [31:0]      val_reg;
  logic             neg_reg;
  logic [WW-1:0]    w_reg;
  logic [1:0]       dec_reg;
  num_fmt_t         fmt_reg;
  logic [WW-1:0]    pos_reg;
  logic [7:0]       buf_reg [WMAX];
  logic [7:0]       xor_reg;
  logic [IDXW-1:0]  ci_reg;
  logic [IDXW-1:0]  last_reg;
  logic [7:0]       hist_reg [HIST_DEPTH];
  logic [IDXW-1:0]  wr_idx_reg;

  logic             is_chk;
  logic [4:0]       req_w;
  logic [WW-1:0]    w_next;
  logic [1:0]       dec_next;
  logic [1:0]       fmt_next;
  logic             req_neg;
  logic [31:0]      req_mag;
  logic [31:0]      val_next;
  logic [3:0]       dig;
  logic [7:0]       ch;
  logic [BW-1:0]    bidx;
  logic             signed_fmt;
  logic             hex_fmt;

  logic             push_valid;
  logic             push_ready;
  logic [7:0]       push_data;
  logic             push;

  logic [TW-1:0]    cyc_reg;
  logic             tick;
  logic [3:0]       noval_s_reg;
  logic [6:0]       fault_s_reg;
  logic             malf;
  logic             stat_flt;
  logic [3:0]       fill_code;
  logic [15:0]      ext_next;

  // ****************************************
  // Output FIFO
  // ****************************************
  char_stream_if #(.WIDTH(8)) fin_s ();
  char_stream_if #(.WIDTH(8)) fout_s ();

  assign fin_s.valid   = push_valid;
  assign fin_s.data    = push_data;
  assign push_ready    = fin_s.ready;
  assign out_valid_o   = fout_s.valid;
  assign out_data_o    = fout_s.data;
  assign fout_s.ready  = out_ready_i;

  char_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .in_s    (fin_s),
    .out_s   (fout_s)
  );

  // ****************************************
  // Request decode
  // ****************************************
  function automatic logic [31:0] round_dec(input logic [31:0] m, input logic [1:0] d);
    logic [31:0] r;
    r = m;
    case (d)
      2'd0:    r = (m + 32'd500) / 32'd1000;
      2'd1:    r = (m + 32'd50) / 32'd100;
      2'd2:    r = (m + 32'd5) / 32'd10;
      default: r = m;
    endcase
    return r;
  endfunction

  assign is_chk  = (fld_id_i == `TFS_CHECK_ID);
  assign req_w   = (fld_nparams_i >= `TFS_NP_WIDTH) ? fld_width_i : `TFS_DEF_WIDTH;
  assign req_neg = fld_value_i[31];
  assign req_mag = req_neg ? (~fld_value_i + 32'd1) : fld_value_i;

  always_comb begin
    w_next = WW'(req_w);
    if (req_w == 5'd0) begin
      w_next = WW'(1);
    end else if ({27'd0, req_w} > WMAX) begin
      w_next = WW'(WMAX);
    end
    if (fld_is_number_i && !is_chk) begin
      dec_next = (fld_nparams_i >= `TFS_NP_DEC) ? fld_dec_i : `TFS_DEF_DEC;
      fmt_next = (fld_nparams_i >= `TFS_NP_FMT_NUM) ? fld_fmt_i : `TFS_DEF_FMT;
      val_next = round_dec(req_mag, dec_next);
    end else begin
      dec_next = 2'd0;
      fmt_next = (fld_nparams_i >= `TFS_NP_FMT_INT) ? fld_fmt_i : `TFS_DEF_FMT;
      val_next = req_mag;
    end
  end

  // ****************************************
  // Character builder
  // ****************************************
  assign signed_fmt = (fmt_reg == FMT_SDEC) || (fmt_reg == FMT_SHEX);
  assign hex_fmt    = (fmt_reg == FMT_UHEX) || (fmt_reg == FMT_SHEX);
  assign dig        = hex_fmt ? val_reg[3:0] : 4'(val_reg % 32'd10);
  assign bidx       = BW'(w_reg - pos_reg - WW'(1));

  always_comb begin
    if (signed_fmt && (pos_reg == w_reg - WW'(1))) begin
      ch = neg_reg ? `TFS_CH_MINUS : `TFS_CH_PLUS;
    end else if ((dec_reg != 2'd0) && (pos_reg == WW'(dec_reg))) begin
      ch = `TFS_CH_DOT;
    end else if (dig < 4'd10) begin
      ch = `TFS_CH_ZERO + {4'h0, dig};
    end else begin
      ch = `TFS_CH_HEXOFS + {4'h0, dig};
    end
  end

  // ****************************************
  // Character path into the FIFO
  // ****************************************
  assign fld_ready_o  = (st_reg == ST_IDLE);
  assign text_ready_o = (st_reg == ST_IDLE) && !fld_valid_i && push_ready;

  always_comb begin
    if (st_reg == ST_EMIT) begin
      push_valid = 1'b1;
      push_data  = buf_reg[pos_reg[BW-1:0]];
    end else begin
      push_valid = (st_reg == ST_IDLE) && !fld_valid_i && text_valid_i;
      push_data  = text_data_i;
    end
  end

  assign push = push_valid && push_ready;

  // ****************************************
  // Field state machine
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg   <= ST_IDLE;
      val_reg  <= '0;
      neg_reg  <= 1'b0;
      w_reg    <= '0;
      dec_reg  <= '0;
      fmt_reg  <= FMT_UDEC;
      pos_reg  <= '0;
      xor_reg  <= '0;
      ci_reg   <= '0;
      last_reg <= '0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (fld_valid_i) begin
            w_reg   <= w_next;
            dec_reg <= dec_next;
            fmt_reg <= num_fmt_t'(fmt_next);
            pos_reg <= '0;
            if (is_chk) begin
              xor_reg  <= '0;
              ci_reg   <= fld_first_i;
              last_reg <= fld_last_i;
              neg_reg  <= 1'b0;
              st_reg   <= ST_CHECK;
            end else begin
              val_reg <= val_next;
              neg_reg <= req_neg && (val_next != 32'd0);
              st_reg  <= ST_BUILD;
            end
          end
        end
        ST_CHECK: begin
          if ((ci_reg >= last_reg) || (ci_reg >= wr_idx_reg)) begin
            val_reg <= {24'd0, xor_reg};
            st_reg  <= ST_BUILD;
          end else begin
            xor_reg <= xor_reg ^ hist_reg[ci_reg[HAW-1:0]];
            ci_reg  <= ci_reg + 1'b1;
          end
        end
        ST_BUILD: begin
          if (!(signed_fmt && (pos_reg == w_reg - WW'(1))) &&
              !((dec_reg != 2'd0) && (pos_reg == WW'(dec_reg)))) begin
            val_reg <= hex_fmt ? (val_reg >> 4) : (val_reg / 32'd10);
          end
          if (pos_reg == w_reg - WW'(1)) begin
            pos_reg <= '0;
            st_reg  <= ST_EMIT;
          end else begin
            pos_reg <= pos_reg + WW'(1);
          end
        end
        ST_EMIT: begin
          if (push_ready) begin
            if (pos_reg == w_reg - WW'(1)) begin
              pos_reg <= '0;
              st_reg  <= ST_IDLE;
            end else begin
              pos_reg <= pos_reg + WW'(1);
            end
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Field characters, right to left
  always_ff @(posedge mclk_i) begin
    if (st_reg == ST_BUILD) begin
      buf_reg[bidx] <= ch;
    end
  end

  // ****************************************
  // Telegram history for the check total
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (push) begin
      if (tel_start_i) begin
        hist_reg[0] <= push_data;
      end else if (wr_idx_reg < IDXW'(HIST_DEPTH)) begin
        hist_reg[wr_idx_reg[HAW-1:0]] <= push_data;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_idx_reg <= '0;
    end else if (tel_start_i) begin
      wr_idx_reg <= push ? IDXW'(1) : '0;
    end else if (push && (wr_idx_reg < IDXW'(HIST_DEPTH))) begin
      wr_idx_reg <= wr_idx_reg + 1'b1;
    end
  end

  assign char_count_o = wr_idx_reg;

  // ****************************************
  // One-second tick
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_reg <= '0;
    end else if (cyc_reg == TW'(TICK_CYCLES - 1)) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  assign tick = (cyc_reg == TW'(TICK_CYCLES - 1));

  // ****************************************
  // Malfunction timers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      noval_s_reg <= '0;
    end else if (new_value_i) begin
      noval_s_reg <= '0;
    end else if (tick && (noval_s_reg < 4'(`TFS_NOVAL_S))) begin
      noval_s_reg <= noval_s_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_s_reg <= '0;
    end else if (!fault_i) begin
      fault_s_reg <= '0;
    end else if (tick && (fault_s_reg <= 7'(`TFS_FAULT_S))) begin
      fault_s_reg <= fault_s_reg + 1'b1;
    end
  end

  always_comb begin
    if (avg_time_s_i < FILLW'(`TFS_AVG_LONG_S)) begin
      malf = (noval_s_reg >= 4'(`TFS_NOVAL_S));
    end else begin
      malf = ({fill_count_i, 1'b0} < {1'b0, avg_time_s_i});
    end
  end

  assign stat_flt = (fault_s_reg > 7'(`TFS_FAULT_S));

  // ****************************************
  // Fill level code
  // ****************************************
  always_comb begin
    fill_code = 4'd0;
    for (int k = 1; k < `TFS_FILL_STEPS; k++) begin
      if (({fill_count_i, 4'h0}) > ({4'h0, fill_cap_i} * FW4'(k))) begin
        fill_code = fill_code + 4'd1;
      end
    end
  end

  // ****************************************
  // Status words
  // ****************************************
  always_comb begin
    ext_next                          = 16'h0000;
    ext_next[`TFS_ST_MALF]            = malf;
    ext_next[`TFS_ST_CRIT]            = heat_crit_i;
    ext_next[`TFS_ST_HEAT]            = heater_on_i;
    ext_next[`TFS_ST_STATIC]          = stat_flt;
    ext_next[`TFS_ST_FILL +: 4]       = fill_code;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_status_o   <= 16'h0000;
      short_status_o <= 8'h00;
    end else begin
      ext_status_o                    <= ext_next;
      short_status_o                  <= 8'h00;
      short_status_o[0]               <= ext_next[`TFS_ST_MALF];
      short_status_o[`TFS_SH_FILL +: 3] <= fill_code[3:1];
      short_status_o[`TFS_SH_STATIC]  <= ext_next[`TFS_ST_STATIC];
      short_status_o[`TFS_SH_CRIT]    <= ext_next[`TFS_ST_CRIT];
      short_status_o[`TFS_SH_HEAT]    <= ext_next[`TFS_ST_HEAT];
    end
  end

endmodule

// File: tb/tfs_checker_sva.sv
// Checker of the formatter's status word and field handshake.
// Assumes binding to the telegram_field_format_status top module.
`timescale 1ns/1ps
module tfs_checker #(
  parameter int FILLW = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  // Field handshake
  input  wire logic             fld_valid_i,
  input  wire logic             fld_ready_o,
  // Status sources and words
  input  wire logic             new_value_i,
  input  wire logic [FILLW-1:0] avg_time_s_i,
  input  wire logic [FILLW-1:0] fill_count_i,
  input  wire logic [FILLW-1:0] fill_cap_i,
  input  wire logic             heat_crit_i,
  input  wire logic             heater_on_i,
  input  wire logic             fault_i,
  input  wire logic [15:0]      ext_status_o,
  input  wire logic [7:0]       short_status_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] fill_exp;
  // ****************************************
  // Expected fill code
  // ****************************************
  always_comb begin
    fill_exp = 4'h0;
    for (int k = 1; k < 16; k++) begin
      if (32'(fill_count_i) * 16 > 32'(fill_cap_i) * k) begin
        fill_exp = fill_exp + 4'h1;
      end
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_resv_zero;
    ext_status_o[15:12] == 4'h0 && ext_status_o[7:5] == 3'h0 && !ext_status_o[3];
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved status bit set");
  property p_fill;
    $past(rst_b_i) |-> ext_status_o[11:8] == $past(fill_exp);
  endproperty
  a_fill: assert property (p_fill) else $error("fill code wrong");
  property p_heat_crit;
    1'b1 |=> ext_status_o[1] == $past(heat_crit_i);
  endproperty
  a_heat_crit: assert property (p_heat_crit) else $error("heat criterion bit wrong");
  property p_heater;
    1'b1 |=> ext_status_o[2] == $past(heater_on_i);
  endproperty
  a_heater: assert property (p_heater) else $error("heater bit missing");
  property p_static_clr;
    !fault_i |-> ##2 !ext_status_o[4];
  endproperty
  a_static_clr: assert property (p_static_clr) else $error("static fault bit stuck");
  property p_long_low;
    avg_time_s_i >= 16'd10 && 32'(fill_count_i) * 2 < 32'(avg_time_s_i) |=> ext_status_o[0];
  endproperty
  a_long_low: assert property (p_long_low) else $error("malfunction bit missing");
  property p_long_ok;
    avg_time_s_i >= 16'd10 && 32'(fill_count_i) * 2 >= 32'(avg_time_s_i) |=> !ext_status_o[0];
  endproperty
  a_long_ok: assert property (p_long_ok) else $error("malfunction bit spurious");
  property p_fresh;
    avg_time_s_i < 16'd10 && new_value_i |-> ##[1:2] !ext_status_o[0];
  endproperty
  a_fresh: assert property (p_fresh) else $error("malfunction after new value");
  property p_short;
    short_status_o == {ext_status_o[2:1], ext_status_o[4], 1'b0, ext_status_o[11:9], ext_status_o[0]};
  endproperty
  a_short: assert property (p_short) else $error("short status not derived");
  property p_busy;
    fld_valid_i && fld_ready_o |=> !fld_ready_o [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("field port not busy");
  c_field: cover property (fld_valid_i && fld_ready_o);
  c_full: cover property (ext_status_o[11:8] == 4'hf);
  c_static: cover property (ext_status_o[4]);
endmodule

bind telegram_field_format_status tfs_checker #(.FILLW(FILLW)) chk_u (
  .mclk_i, .rst_b_i, .fld_valid_i, .fld_ready_o, .new_value_i, .avg_time_s_i, .fill_count_i,
  .fill_cap_i, .heat_crit_i, .heater_on_i, .fault_i, .ext_status_o, .short_status_o
);

// File: tb/tfs_host_sink.sv
// Host model: takes telegram characters off the output stream.
// Assumes the stream is sampled on the rising clock edge.
`timescale 1ns/1ps
module tfs_host_sink (
  // Clock and control
  input  wire logic       mclk_i,
  input  wire logic       stall_i,
  // Character stream
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o
);
  logic [7:0] got[$];
  initial ready_o = 1'b0;
  always @(negedge mclk_i) begin
    ready_o <= !stall_i;
  end
  always @(posedge mclk_i) begin
    if (valid_i === 1'b1 && ready_o === 1'b1) begin
      got.push_back(data_i);
    end
  end
endmodule

// File: tb/tb_telegram_field_format_status.sv
// Self-checking bench of the telegram formatter and status word.
// Assumes the host model drains the character output.
`timescale 1ns/1ps
module tb_telegram_field_format_status;
  import telegram_pkg::*;
  typedef struct {
    logic [4:0]  id;
    logic        num;
    logic [2:0]  np;
    logic [31:0] val;
    logic [4:0]  w;
    logic [1:0]  dec;
    logic [1:0]  fmt;
    string       exp;
  } row_t;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, fld_valid_i = 1'b0, fld_is_number_i = 1'b0;
  logic        tel_start_i = 1'b0, text_valid_i = 1'b0, new_value_i = 1'b0, stall = 1'b0;
  logic        heat_crit_i = 1'b0, heater_on_i = 1'b0, fault_i = 1'b0;
  logic [4:0]  fld_id_i = 5'h0, fld_width_i = 5'h0;
  logic [2:0]  fld_nparams_i = 3'h0;
  logic [31:0] fld_value_i = 32'h0;
  logic [1:0]  fld_dec_i = 2'h0, fld_fmt_i = 2'h0;
  logic [7:0]  fld_first_i = 8'h0, fld_last_i = 8'h0, text_data_i = 8'h0, out_data_o, char_count_o;
  logic [15:0] avg_time_s_i = 16'd20, fill_count_i = 16'd16, fill_cap_i = 16'd16, ext_status_o, e;
  logic [7:0]  short_status_o;
  logic        fld_ready_o, text_ready_o, out_valid_o, out_ready_i;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          acc;
  row_t rows[11] = '{
    '{5'd7, 1'b1, 3'd3, -32'sd21500, 5'd8, 2'd2, 2'd1, "-0021.50"},
    '{5'd6, 1'b1, 3'd0, 32'd181000, 5'd9, 2'd3, 2'd3, "181"},
    '{5'd5, 1'b1, 3'd3, 32'd60, 5'd6, 2'd2, 2'd0, "000.06"},
    '{5'd5, 1'b1, 3'd3, 32'd12345, 5'd6, 2'd2, 2'd0, "012.35"},
    '{5'd17, 1'b0, 3'd2, 32'd255, 5'd3, 2'd0, 2'd2, "0FF"},
    '{5'd2, 1'b0, 3'd2, -32'sd26, 5'd4, 2'd0, 2'd3, "-01A"},
    '{5'd8, 1'b0, 3'd2, 32'd42, 5'd4, 2'd0, 2'd1, "+042"},
    '{5'd17, 1'b0, 3'd0, 32'd7, 5'd9, 2'd0, 2'd3, "007"},
    '{5'd4, 1'b1, 3'd3, 32'd1234, 5'd5, 2'd1, 2'd0, "001.2"},
    '{5'd9, 1'b1, 3'd3, 32'd7654, 5'd6, 2'd3, 2'd1, "+7.654"},
    '{5'd6, 1'b1, 3'd1, 32'd181500, 5'd4, 2'd2, 2'd3, "0182"}};
  logic [15:0] fills[4] = '{16'd16, 16'd1, 16'd10, 16'd8};
  logic [15:0] exps[4] = '{16'h0f00, 16'h0001, 16'h0900, 16'h0701};

  telegram_field_format_status #(.TICK_CYCLES(10)) dut_u (
    .mclk_i, .rst_b_i, .fld_valid_i, .fld_ready_o, .fld_id_i, .fld_is_number_i, .fld_nparams_i,
    .fld_value_i, .fld_width_i, .fld_dec_i, .fld_fmt_i, .fld_first_i, .fld_last_i, .tel_start_i,
    .text_valid_i, .text_ready_o, .text_data_i, .out_valid_o, .out_ready_i, .out_data_o,
    .char_count_o, .new_value_i, .avg_time_s_i, .fill_count_i, .fill_cap_i, .heat_crit_i,
    .heater_on_i, .fault_i, .ext_status_o, .short_status_o);
  tfs_host_sink host_u (.mclk_i, .stall_i(stall), .valid_i(out_valid_o), .data_i(out_data_o),
    .ready_o(out_ready_i));

  always #10 mclk_i = ~mclk_i;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    n_fail++;
    $display("unexpected at %0t: wait ran out", $time);
    results();
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_str(input string exp);
    int n;
    n = 0;
    while (host_u.got.size() < exp.len() && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 400) timeout();
    repeat (3) @(negedge mclk_i);
    chk_word(16'(host_u.got.size()), 16'(exp.len()));
    for (int i = 0; i < exp.len(); i++) begin
      chk_word({8'h0, host_u.got[i]}, {8'h0, exp[i]});
    end
    host_u.got.delete();
  endtask
  task automatic field(input row_t r, input logic [7:0] first, input logic [7:0] last);
    int n;
    @(negedge mclk_i);
    {fld_id_i, fld_is_number_i, fld_nparams_i, fld_value_i} = {r.id, r.num, r.np, r.val};
    {fld_width_i, fld_dec_i, fld_fmt_i, fld_first_i, fld_last_i} = {r.w, r.dec, r.fmt, first, last};
    fld_valid_i = 1'b1;
    n = 0;
    while (fld_ready_o !== 1'b1 && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 400) timeout();
    @(negedge mclk_i);
    fld_valid_i = 1'b0;
  endtask
  task automatic restart();
    @(negedge mclk_i);
    tel_start_i = 1'b1;
    @(negedge mclk_i);
    tel_start_i = 1'b0;
  endtask
  task automatic put_text(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      @(negedge mclk_i);
      text_data_i = s[i];
      text_valid_i = 1'b1;
      n = 0;
      while (text_ready_o !== 1'b1 && n < 400) begin
        @(negedge mclk_i);
        n++;
      end
      if (n >= 400) timeout();
    end
    @(negedge mclk_i);
    text_valid_i = 1'b0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0000);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      field(rows[i], 8'h0, 8'h0);
      chk_str(rows[i].exp);
    end
    restart();
    put_text("AABBCC");
    field('{5'd24, 1'b0, 3'd2, 32'h0, 5'd2, 2'd0, 2'd2, ""}, 8'd2, 8'd4);
    chk_str("AABBCC00");
    field('{5'd24, 1'b0, 3'd2, 32'h0, 5'd2, 2'd0, 2'd2, ""}, 8'd2, 8'd3);
    chk_str("42");
    field('{5'd24, 1'b0, 3'd2, 32'h0, 5'd4, 2'd0, 2'd1, ""}, 8'd0, 8'd1);
    chk_str("+065");
    restart();
    stall = 1'b1;
    acc = 0;
    repeat (2) @(negedge mclk_i);
    text_data_i = 8'h61;
    text_valid_i = 1'b1;
    for (int i = 0; i < 24; i++) begin
      if (text_ready_o === 1'b1) acc++;
      @(negedge mclk_i);
      text_data_i = 8'h61 + 8'(acc);
    end
    text_valid_i = 1'b0;
    stall = 1'b0;
    chk_word(16'(acc), 16'd16);
    chk_word({8'h0, char_count_o}, 16'd16);
    chk_str("abcdefghijklmnop");
    field('{5'd24, 1'b0, 3'd2, 32'h0, 5'd2, 2'd0, 2'd2, ""}, 8'd0, 8'd16);
    chk_str("10");
    for (int i = 0; i < 4; i++) begin
      fill_count_i = fills[i];
      {heater_on_i, heat_crit_i} = 2'(i);
      e = exps[i] | {13'h0, 2'(i), 1'b0};
      repeat (3) @(negedge mclk_i);
      chk_word(ext_status_o, e);
      chk_word({8'h0, short_status_o}, {8'h0, e[2:1], e[4], 1'b0, e[11:9], e[0]});
    end
    {fill_count_i, avg_time_s_i, heater_on_i, heat_crit_i} = {16'd16, 16'd5, 2'b00};
    new_value_i = 1'b1;
    @(negedge mclk_i);
    new_value_i = 1'b0;
    repeat (60) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f00);
    repeat (60) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f01);
    new_value_i = 1'b1;
    @(negedge mclk_i);
    new_value_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f00);
    avg_time_s_i = 16'd20;
    fault_i = 1'b1;
    repeat (590) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f00);
    repeat (70) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f10);
    fault_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f00);
    rst_b_i = 1'b0;
    @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0000);
    chk_word({8'h0, char_count_o}, 16'h0000);
    rst_b_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_word(ext_status_o, 16'h0f00);
    results();
  end
endmodule
